// >>> sp_consts.svh
// Purpose: named constants of the dual serial port block
// Assumes: 125 MHz system clock, byte addresses on the register bus
// Notes: included by the top module and the testbench
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH
// clock and baud figures
`define SP_CLK_HZ        125000000
`define SP_BAUD_300      300
`define SP_BAUD_600      600
`define SP_BAUD_1200     1200
`define SP_BAUD_2400     2400
`define SP_BAUD_4800     4800
`define SP_BAUD_9600     9600
`define SP_BAUD_19200    19200
// baud codes
`define SP_BC_300        3'h0
`define SP_BC_600        3'h1
`define SP_BC_1200       3'h2
`define SP_BC_2400       3'h3
`define SP_BC_4800       3'h4
`define SP_BC_9600       3'h5
// register byte offsets, one word each
`define SP_OFS_CTRL      6'h00
`define SP_OFS_STAT      6'h04
`define SP_OFS_STORED0   6'h08
`define SP_OFS_STORED1   6'h0C
`define SP_OFS_ACTIVE0   6'h10
`define SP_OFS_ACTIVE1   6'h14
`define SP_OFS_DATA0     6'h18
`define SP_OFS_DATA1     6'h1C
// configuration word: 19200, 8 bits, no parity, 1 stop, no 422/485, flow on
`define SP_CFG_RESET     16'h0216
// writable configuration bits; port 0 has no 422/485 option
`define SP_CFG_MASK1     16'h03FF
`define SP_CFG_MASK0     16'h02FF
// parity codes
`define SP_PAR_NONE      2'h0
`define SP_PAR_EVEN      2'h1
// data bit codes: 0 = 6 bits, 1 = 7 bits, 2 = 8 bits
`define SP_DB_6          2'h0
`define SP_DB_7          2'h1
`define SP_DIV_W         20
`define SP_FIFO_DEPTH    8
`define SP_CTS_SLACK     2
`endif

// >>> sp_pkg.sv
// Purpose: types shared by the dual serial port block
// Assumes: nothing beyond the constants header
// Notes: configuration word layout of each port
package sp_pkg;
  // one port's character and line configuration
  typedef struct packed {
    logic [5:0] pad;     // reads as zero; protocol is always plain ASCII
    logic       flow;    // hardware handshaking enable
    logic       rs485;   // 422/485 line operation
    logic       stop2;   // two stop bits
    logic [1:0] parity;  // none, even, odd
    logic [1:0] dbits;   // 6, 7 or 8 data bits
    logic [2:0] baud;    // 300 .. 19200 code
  } sp_cfg_t;
  // transmitter and receiver states, one-hot
  typedef enum logic [4:0] {
    SP_IDLE  = 5'h01,
    SP_START = 5'h02,
    SP_DATA  = 5'h04,
    SP_PAR   = 5'h08,
    SP_STOP  = 5'h10
  } sp_state_t;
endpackage

// >>> sp_serial_top.sv
// Purpose: two asynchronous serial ports with flow control behind Avalon-MM
// Assumes: pins are asynchronous to SYS_CLK, master keeps Avalon rules
// Notes: per-port transmit and receive FIFOs of eight characters
// Summary of operation
// - per-port baud rate from 300 to 19200
// - 6-8 data bits, parity, 1/2 stops, 485
// - CTS drops when receiver has only two places or fewer left
// - transmit waits while RTS input is deasserted
// - stored settings applied when program starts running
// - runtime reconfiguration overrides the stored settings
// - restart discards runtime changes, reapplies stored settings
// - ports offer plain ASCII protocol only
// - port 1 RS-232 only, port 2 selectable
`timescale 1ns/100ps
`include "sp_consts.svh"

// simple synchronous FIFO with valid/ready on both sides
module sp_fifo #(
  parameter int W = 8,
  parameter int D = `SP_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [W-1:0]     in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [W-1:0]          out_data,
  output logic [$clog2(D+1)-1:0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];  // storage
  logic [AW-1:0] wr_ptr;   // write index
  logic [AW-1:0] rd_ptr;   // read index
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  assign in_ready  = (count != ($clog2(D+1))'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  // storage write, no reset needed
  always_ff @(posedge clk)
  begin
    if (en & push)
      mem[wr_ptr] <= in_data;
  end
  // pointers and fill count
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (en)
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (($clog2(D+1))'(push)) - (($clog2(D+1))'(pop));
    end
  end
endmodule

module sp_serial_top #(
  parameter int DEPTH = `SP_FIFO_DEPTH
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic [1:0]       TXD,
  input  wire logic [1:0]  RXD,
  output logic [1:0]       CTS,
  input  wire logic [1:0]  RTS,
  output logic             TXD_485,
  input  wire logic        RXD_485,
  output logic             DE_485
);
  localparam int CW = $clog2(DEPTH+1);

  // bit period in clocks for a baud code
  function automatic logic [`SP_DIV_W-1:0] baud_div(input logic [2:0] code);
    case (code)
      `SP_BC_300:  baud_div = `SP_DIV_W'(`SP_CLK_HZ / `SP_BAUD_300);
      `SP_BC_600:  baud_div = `SP_DIV_W'(`SP_CLK_HZ / `SP_BAUD_600);
      `SP_BC_1200: baud_div = `SP_DIV_W'(`SP_CLK_HZ / `SP_BAUD_1200);
      `SP_BC_2400: baud_div = `SP_DIV_W'(`SP_CLK_HZ / `SP_BAUD_2400);
      `SP_BC_4800: baud_div = `SP_DIV_W'(`SP_CLK_HZ / `SP_BAUD_4800);
      `SP_BC_9600: baud_div = `SP_DIV_W'(`SP_CLK_HZ / `SP_BAUD_9600);
      default:     baud_div = `SP_DIV_W'(`SP_CLK_HZ / `SP_BAUD_19200);
    endcase
  endfunction

  // number of data bits for a data bit code
  function automatic logic [3:0] data_bits(input logic [1:0] code);
    case (code)
      `SP_DB_6: data_bits = 4'h6;
      `SP_DB_7: data_bits = 4'h7;
      default:  data_bits = 4'h8;
    endcase
  endfunction

  // pin synchronisers: RXD, RTS and the 485 receive line
  logic [4:0] sync1;  // first stage, read only by sync2
  logic [4:0] sync2;  // settled pin levels
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
    end
    else if (CE)
    begin
      sync1 <= {RXD_485, RTS, RXD};
      sync2 <= sync1;
    end
  end

  // program run flag and per-port configuration
  logic           run;              // controlling program running
  sp_pkg::sp_cfg_t stored_cfg [2];  // downloaded settings
  sp_pkg::sp_cfg_t active_cfg [2];  // settings in use by the hardware

  // bus decode
  wire        req      = AVS_READ | AVS_WRITE;
  wire [2:0]  reg_sel  = AVS_ADDRESS[4:2];
  wire        mapped   = (AVS_ADDRESS[5] == 1'b0) && (AVS_ADDRESS[1:0] == 2'h0);
  wire        hit_ctrl = mapped && (AVS_ADDRESS == `SP_OFS_CTRL);
  wire        hit_stat = mapped && (AVS_ADDRESS == `SP_OFS_STAT);
  wire [1:0]  hit_sto  = {AVS_ADDRESS == `SP_OFS_STORED1, AVS_ADDRESS == `SP_OFS_STORED0};
  wire [1:0]  hit_act  = {AVS_ADDRESS == `SP_OFS_ACTIVE1, AVS_ADDRESS == `SP_OFS_ACTIVE0};
  wire [1:0]  hit_dat  = {AVS_ADDRESS == `SP_OFS_DATA1, AVS_ADDRESS == `SP_OFS_DATA0};
  wire        run_on   = AVS_WRITE && hit_ctrl && AVS_WRITEDATA[0];
  logic       ack;                  // answer cycle of the current request
  logic [1:0] tx_in_ready;          // transmit FIFO has room
  logic [1:0] rx_out_valid;         // receive FIFO holds a character
  logic [8:0] rx_out_data [2];      // error flag and character
  logic [1:0] tx_busy;              // transmitter not idle
  // a write to a full transmit FIFO is stalled until room appears
  wire        stall    = AVS_WRITE && |(hit_dat & ~tx_in_ready);
  wire        take     = req & ack;
  wire [1:0]  tx_push  = {2{take & AVS_WRITE}} & hit_dat;
  wire [1:0]  rx_pop   = {2{take & AVS_READ}} & hit_dat & rx_out_valid;
  assign AVS_WAITREQUEST = ~ack;

  // read data selection
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (reg_sel)
      3'h0: rd_mux = {31'h0, run};
      3'h1: rd_mux = {26'h0, tx_busy, rx_out_valid, ~tx_in_ready};
      3'h2: rd_mux = {16'h0, stored_cfg[0]};
      3'h3: rd_mux = {16'h0, stored_cfg[1]};
      3'h4: rd_mux = {16'h0, active_cfg[0]};
      3'h5: rd_mux = {16'h0, active_cfg[1]};
      3'h6: rd_mux = {22'h0, rx_out_valid[0], rx_out_data[0]};
      3'h7: rd_mux = {22'h0, rx_out_valid[1], rx_out_data[1]};
      default: rd_mux = 32'h0;
    endcase
    if (!mapped)
      rd_mux = 32'h0;  // unmapped addresses read zero
  end

  // bus answer: one wait cycle, registered read data
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ack          <= 1'b0;
      AVS_READDATA <= 32'h0;
    end
    else if (CE)
    begin
      ack <= req & ~ack & ~stall;
      // only reads load the data register, so it stands until the next read
      if (AVS_READ & ~ack)
        AVS_READDATA <= rd_mux;
    end
  end

  // run flag and configuration registers
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      run <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        stored_cfg[i] <= `SP_CFG_RESET;
        active_cfg[i] <= `SP_CFG_RESET;
      end
    end
    else if (CE && take && AVS_WRITE)
    begin
      if (hit_ctrl)
        run <= AVS_WRITEDATA[0];
      for (int i = 0; i < 2; i++)
      begin
        // port 0 keeps 422/485 cleared, protocol bits stay zero
        if (hit_sto[i])
          stored_cfg[i] <= AVS_WRITEDATA[15:0] & (i == 0 ? `SP_CFG_MASK0 : `SP_CFG_MASK1);
        if (run_on && !run)
          active_cfg[i] <= stored_cfg[i];
        else if (hit_act[i])
          active_cfg[i] <= AVS_WRITEDATA[15:0] & (i == 0 ? `SP_CFG_MASK0 : `SP_CFG_MASK1);
      end
    end
  end

  logic [1:0] tx_line;  // transmit line per port
  logic [1:0] cts_q;    // clear-to-send per port

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : port
      sp_pkg::sp_cfg_t  cfg;
      logic [`SP_DIV_W-1:0] div;
      logic [3:0]       nbits;
      // port 2 may receive on the 485 pair
      assign cfg   = active_cfg[g];
      assign div   = baud_div(cfg.baud);
      assign nbits = data_bits(cfg.dbits);
      wire rxd_s   = (g == 1 && cfg.rs485) ? sync2[4] : sync2[g];
      wire rts_s   = sync2[2+g];

      // transmit path
      logic            tq_valid;
      logic [7:0]      tq_data;
      sp_pkg::sp_state_t tst;
      logic [`SP_DIV_W-1:0] tcnt;
      logic [7:0]      tsh;
      logic [3:0]      tbit;
      logic            tpar;
      logic            tstop;
      wire tx_allow = ~cfg.flow | rts_s;
      wire tx_pop   = (tst == sp_pkg::SP_IDLE) & tq_valid & tx_allow;
      wire ttick    = (tcnt == '0);
      wire [7:0] tmask = 8'hFF >> (4'h8 - nbits);
      sp_fifo #(.W(8), .D(DEPTH)) tx_fifo (
        .clk(SYS_CLK), .rst(RST), .en(CE),
        .in_valid(tx_push[g]), .in_ready(tx_in_ready[g]), .in_data(AVS_WRITEDATA[7:0]),
        .out_valid(tq_valid), .out_ready(tx_pop), .out_data(tq_data), .count());
      assign tx_busy[g] = (tst != sp_pkg::SP_IDLE);

      // transmitter: start, data LSB first, optional parity, stop bits
      always_ff @(posedge SYS_CLK)
      begin
        if (RST)
        begin
          tst <= sp_pkg::SP_IDLE;
          tcnt <= '0;
          tsh <= 8'h00;
          tbit <= 4'h0;
          tpar <= 1'b0;
          tstop <= 1'b0;
          tx_line[g] <= 1'b1;
        end
        else if (CE)
        begin
          tcnt <= ttick ? div - 1'b1 : tcnt - 1'b1;
          case (tst)
            sp_pkg::SP_IDLE:
            begin
              tcnt <= div - 1'b1;
              if (tx_pop)
              begin
                tsh <= tq_data & tmask;
                tpar <= ^(tq_data & tmask) ^ (cfg.parity != `SP_PAR_EVEN);
                tx_line[g] <= 1'b0;
                tst <= sp_pkg::SP_START;
              end
            end
            sp_pkg::SP_START:
              if (ttick)
              begin
                tx_line[g] <= tsh[0];
                tsh <= tsh >> 1;
                tbit <= 4'h1;
                tst <= sp_pkg::SP_DATA;
              end
            sp_pkg::SP_DATA:
              if (ttick)
              begin
                if (tbit == nbits)
                begin
                  tstop <= 1'b0;
                  tx_line[g] <= (cfg.parity == `SP_PAR_NONE) ? 1'b1 : tpar;
                  tst <= (cfg.parity == `SP_PAR_NONE) ? sp_pkg::SP_STOP : sp_pkg::SP_PAR;
                end
                else
                begin
                  tx_line[g] <= tsh[0];
                  tsh <= tsh >> 1;
                  tbit <= tbit + 1'b1;
                end
              end
            sp_pkg::SP_PAR:
              if (ttick)
              begin
                tx_line[g] <= 1'b1;
                tst <= sp_pkg::SP_STOP;
              end
            sp_pkg::SP_STOP:
              if (ttick)
              begin
                if (cfg.stop2 && !tstop)
                  tstop <= 1'b1;   // second stop bit
                else
                  tst <= sp_pkg::SP_IDLE;
              end
            default: tst <= sp_pkg::SP_IDLE;
          endcase
        end
      end

      // receive path
      sp_pkg::sp_state_t rst_q;
      logic [`SP_DIV_W-1:0] rcnt;
      logic [7:0]      rsh;
      logic [3:0]      rbit;
      logic            rpar;
      logic            rpush;
      logic [8:0]      rword;
      logic [CW-1:0]   rcount;
      wire rtick = (rcnt == '0);
      wire [7:0] rdat = rsh >> (4'h8 - nbits);
      sp_fifo #(.W(9), .D(DEPTH)) rx_fifo (
        .clk(SYS_CLK), .rst(RST), .en(CE),
        .in_valid(rpush), .in_ready(), .in_data(rword),
        .out_valid(rx_out_valid[g]), .out_ready(rx_pop[g]), .out_data(rx_out_data[g]),
        .count(rcount));

      // receiver: mid-bit sampling, error flag for parity or missing stop
      always_ff @(posedge SYS_CLK)
      begin
        if (RST)
        begin
          rst_q <= sp_pkg::SP_IDLE;
          rcnt <= '0;
          rsh <= 8'h00;
          rbit <= 4'h0;
          rpar <= 1'b0;
          rpush <= 1'b0;
          rword <= 9'h000;
          cts_q[g] <= 1'b0;
        end
        else if (CE)
        begin
          rpush <= 1'b0;
          // leave room for characters already on their way
          cts_q[g] <= ~cfg.flow | (rcount < CW'(DEPTH - `SP_CTS_SLACK));
          rcnt <= rtick ? div - 1'b1 : rcnt - 1'b1;
          case (rst_q)
            sp_pkg::SP_IDLE:
            begin
              rcnt <= div >> 1;
              if (!rxd_s)
                rst_q <= sp_pkg::SP_START;
            end
            sp_pkg::SP_START:
              if (rtick)
              begin
                rbit <= 4'h0;
                rst_q <= rxd_s ? sp_pkg::SP_IDLE : sp_pkg::SP_DATA;  // glitch rejected
              end
            sp_pkg::SP_DATA:
              if (rtick)
              begin
                rsh <= {rxd_s, rsh[7:1]};
                rbit <= rbit + 1'b1;
                if (rbit == nbits - 1'b1)
                  rst_q <= (cfg.parity == `SP_PAR_NONE) ? sp_pkg::SP_STOP : sp_pkg::SP_PAR;
                rpar <= 1'b0;
              end
            sp_pkg::SP_PAR:
              if (rtick)
              begin
                rpar <= rxd_s ^ ^rdat ^ (cfg.parity != `SP_PAR_EVEN);
                rst_q <= sp_pkg::SP_STOP;
              end
            sp_pkg::SP_STOP:
              if (rtick)
              begin
                rword <= {rpar | ~rxd_s, rdat};
                rpush <= 1'b1;   // dropped if the FIFO is full: flow off, or sender ignores CTS
                rst_q <= sp_pkg::SP_IDLE;
              end
            default: rst_q <= sp_pkg::SP_IDLE;
          endcase
        end
      end
    end
  endgenerate

  // line outputs from flip-flops; port 2 drives the 485 pair when enabled
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      TXD     <= 2'h3;
      CTS     <= 2'h0;
      TXD_485 <= 1'b1;
      DE_485  <= 1'b0;
    end
    else if (CE)
    begin
      TXD     <= {tx_line[1] | active_cfg[1].rs485, tx_line[0]};
      CTS     <= cts_q;
      TXD_485 <= tx_line[1];
      DE_485  <= active_cfg[1].rs485 & tx_busy[1];
    end
  end
endmodule

// >>> sp_serial_top_asserts.sv
// Purpose: bus and line checks on the dual serial port top
// Assumes: one clock domain, reset synchronous active high
// Notes: bound to the top; sees its ports only
`timescale 1ns/100ps
module sp_serial_top_chk #(
  parameter int DEPTH = 8
) (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic [5:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [1:0]  TXD,
  input wire logic [1:0]  CTS,
  input wire logic        TXD_485,
  input wire logic        DE_485
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // decode of the word being read
  wire unmapped = AVS_ADDRESS[5] | (|AVS_ADDRESS[1:0]);  // off the map
  wire cfg_any  = !unmapped && (AVS_ADDRESS[4:2] inside {3'h2, 3'h3, 3'h4, 3'h5});
  wire cfg_p0   = !unmapped && (AVS_ADDRESS[4:2] inside {3'h2, 3'h4});  // first port
  wire rd_done  = AVS_READ && !AVS_WAITREQUEST;  // read taken at this edge

  AST_RD_ANSWER: assert property (CE && AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("read not answered one cycle later");
  AST_ACK_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  AST_IDLE_WAIT: assert property ((!AVS_READ && !AVS_WRITE) [*2] |-> AVS_WAITREQUEST)
    else $error("waitrequest low with no request");
  AST_RD_HOLD: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data changed without a read");
  AST_UNMAPPED: assert property (rd_done && unmapped |-> AVS_READDATA == 32'h0)
    else $error("unmapped read returned data");
  AST_PAD_ZERO: assert property (rd_done && cfg_any |-> AVS_READDATA[31:10] == 22'h0)
    else $error("configuration pad bits not zero");
  AST_P0_NO485: assert property (rd_done && cfg_p0 |-> !AVS_READDATA[8])
    else $error("first port shows line option");
  AST_DE_TXD1: assert property (DE_485 |-> TXD[1])
    else $error("second port plain line active while driver enabled");
  AST_RST_LINES: assert property ($fell(RST) |-> TXD == 2'h3 && TXD_485 && !DE_485)
    else $error("serial lines not idle out of reset");
  AST_CTS_RISE: assert property ($fell(RST) |-> CTS == 2'h0 ##2 CTS == 2'h3)
    else $error("clear to send not raised with empty receiver");
endmodule
bind sp_serial_top sp_serial_top_chk #(.DEPTH(DEPTH)) u_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .TXD(TXD), .CTS(CTS), .TXD_485(TXD_485),
  .DE_485(DE_485)
);

// >>> sp_line_partner.sv
// Purpose: far-side serial device on both ports
// Assumes: frames of 6 data bits, even parity, one stop bit
// Notes: port 0 ties its clear-to-send back; port 1 permission set by bench
`timescale 1ns/100ps
module sp_line_partner #(
  parameter int BIT_CLKS = 6510
) (
  input  wire logic       clk,
  input  wire logic [1:0] txd,
  input  wire logic [1:0] cts,
  input  wire logic       rts1_allow,
  output logic      [1:0] rxd,
  output logic      [1:0] rts,
  output logic            rxd_485
);
  // lines rest at mark
  initial
  begin
    rxd     = 2'h3;
    rxd_485 = 1'b1;
  end
  // permission lines
  always @(posedge clk)
  begin
    rts[0] <= cts[0];
    rts[1] <= rts1_allow;
  end
  // send one character on port 0 once the block lets us
  task automatic send_char(input logic [5:0] d);
    logic [8:0] frame;
    int         n;
    frame = {1'b1, ^d, d, 1'b0};
    n = 0;
    while (cts[0] !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      rxd[0] <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask
  // take one character from port 1, sampled mid-bit
  task automatic recv_char(output logic [6:0] got, output logic ok);
    int n;
    n = 0;
    while (txd[1] !== 1'b0 && n < 4 * BIT_CLKS)
    begin
      @(negedge clk);
      n++;
    end
    ok = (n < 4 * BIT_CLKS);
    repeat (BIT_CLKS / 2) @(negedge clk);
    for (int i = 0; i < 7; i++)
    begin
      repeat (BIT_CLKS) @(negedge clk);
      got[i] = txd[1];
    end
    repeat (BIT_CLKS) @(negedge clk);
    ok = ok && (txd[1] === 1'b1);
  endtask
endmodule

// >>> tb.sv
// Purpose: self-checking bench of the dual serial port block
// Assumes: partner frames of 6 bits, even parity, one stop, 19200 baud
// Notes: registers reached through Avalon-MM tasks
`timescale 1ns/100ps
`include "sp_consts.svh"
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module tb;
  localparam int BIT_CLKS = `SP_CLK_HZ / `SP_BAUD_19200;  // clocks per bit
  logic            SYS_CLK, RST, CE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [5:0]      AVS_ADDRESS;
  logic [31:0]     AVS_WRITEDATA, AVS_READDATA, rd;
  logic [1:0]      TXD, RXD, CTS, RTS;
  logic            TXD_485, RXD_485, DE_485, rts1_allow, ok, held;
  logic [6:0]      got;
  int              mismatches, samples_checked;
  sp_pkg::sp_cfg_t cfg_run;  // setting used for traffic
  sp_serial_top #(.DEPTH(`SP_FIFO_DEPTH)) uut (
    .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TXD(TXD),
    .RXD(RXD), .CTS(CTS), .RTS(RTS), .TXD_485(TXD_485), .RXD_485(RXD_485),
    .DE_485(DE_485)
  );
  sp_line_partner #(.BIT_CLKS(BIT_CLKS)) partner (
    .clk(SYS_CLK), .txd(TXD), .cts(CTS), .rts1_allow(rts1_allow), .rxd(RXD),
    .rts(RTS), .rxd_485(RXD_485)
  );
  // 125 MHz clock
  initial
    SYS_CLK = 1'b0;
  always #4 SYS_CLK = ~SYS_CLK;
  // one transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    @(posedge SYS_CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= wd;
    AVS_READ      <= !wr;
    AVS_WRITE     <= wr;
    n = 0;
    // waitrequest and read data are sampled at the rising edge only
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 4000);
    if (n >= 4000)
      mismatches++;  // slave never answered
    rd = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  // read and compare
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask
  task automatic note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {RST, CE, AVS_READ, AVS_WRITE, rts1_allow} = 5'h18;
    AVS_ADDRESS = 6'h00;
    AVS_WRITEDATA = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    cfg_run = '{pad: 6'h00, flow: 1'b1, rs485: 1'b0, stop2: 1'b0,
                parity: `SP_PAR_EVEN, dbits: `SP_DB_6, baud: 3'h6};
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 4; i++)
      rdchk(`SP_OFS_STORED0 + 6'(4 * i), {16'h0, `SP_CFG_RESET});
    `CHK(CTS, 2'h3);
    `CHK(TXD, 2'h3);
    note("defaults");
    // unmapped places and masked fields
    bus(1'b1, 6'h20, 32'hFFFF_FFFF);
    rdchk(6'h20, 32'h0);
    rdchk(6'h05, 32'h0);
    bus(1'b1, `SP_OFS_STORED1, 32'hFFFF_FFFF);
    rdchk(`SP_OFS_STORED1, {16'h0, `SP_CFG_MASK1});
    bus(1'b1, `SP_OFS_STORED0, 32'hFFFF_FFFF);
    rdchk(`SP_OFS_STORED0, {16'h0, `SP_CFG_MASK0});
    rdchk(`SP_OFS_ACTIVE0, {16'h0, `SP_CFG_RESET});
    note("masks");
    // start, override, restart
    bus(1'b1, `SP_OFS_STORED0, {16'h0, cfg_run});
    bus(1'b1, `SP_OFS_STORED1, {16'h0, cfg_run});
    bus(1'b1, `SP_OFS_CTRL, 32'h1);
    rdchk(`SP_OFS_ACTIVE0, {16'h0, cfg_run});
    rdchk(`SP_OFS_ACTIVE1, {16'h0, cfg_run});
    bus(1'b1, `SP_OFS_ACTIVE0, 32'h0000_0316);
    rdchk(`SP_OFS_ACTIVE0, 32'h0000_0216);
    bus(1'b1, `SP_OFS_CTRL, 32'h0);
    bus(1'b1, `SP_OFS_CTRL, 32'h1);
    rdchk(`SP_OFS_ACTIVE0, {16'h0, cfg_run});
    note("run control");
    // port 1 holds its character until permitted, then both lines carry one
    bus(1'b1, `SP_OFS_DATA1, 32'h0000_002D);
    held = 1'b1;
    repeat (400)
    begin
      @(negedge SYS_CLK);
      held = held & (TXD[1] === 1'b1);
    end
    `CHK(held, 1'b1);
    @(posedge SYS_CLK);
    rts1_allow <= 1'b1;
    fork
      partner.recv_char(got, ok);
      partner.send_char(6'h13);
    join
    `CHK(got, {^6'h2D, 6'h2D});
    `CHK(ok, 1'b1);
    rdchk(`SP_OFS_DATA0, 32'h0000_0213);
    bus(1'b0, `SP_OFS_DATA0, 32'h0);
    `CHK(rd[9], 1'b0);
    note("serial");
    // second port on the 485 pair: plain line parked, driver enabled
    bus(1'b1, `SP_OFS_ACTIVE1, {16'h0, cfg_run} | 32'h0000_0100);
    bus(1'b1, `SP_OFS_DATA1, 32'h0000_0015);
    rdchk(`SP_OFS_STAT, 32'h0000_0020);
    `CHK(DE_485, 1'b1);
    `CHK(TXD_485, 1'b0);
    `CHK(TXD[1], 1'b1);
    note("line 485");
    final_report();
  end
  // watchdog: the run needs about 60000 cycles
  initial
  begin
    repeat (95000) @(posedge SYS_CLK);
    mismatches++;
    final_report();
  end
endmodule
